/* File: hw/card_host_xfer_mode_regs.sv */
// register bank: command argument and transfer-mode control
// assumes an APB master on sys_clk, and a sequencer that reports data-line busy
//
// Chosen here: register access over APB.
module card_host_xfer_mode_regs #(
  parameter bit DMA_SUPPORTED = 1'b1  // capability strap for DMA
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clkEn,  // freezes all state while low
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // card-side sequencer
  input wire logic dataLineBusyInhibit,  // data_line_busy_inhibit status
  input wire logic blockDone,  // one pulse per completed block
  output logic [31:0] cmdArgument,  // to frame bits 39-8
  output xfer_mode_pkg::mode_fields_t modeFields,
  output xfer_mode_pkg::xfer_kind_t xferKind,
  output logic dmaStart,  // one-cycle pulse
  output logic autoStopIssue  // one-cycle pulse: send stop_transmission_cmd
);

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic [15:0] modeReg;  // transfer_mode_control contents
  logic [15:0] blockCount;  // remaining blocks
  logic wrAccess;  // write taken this edge
  logic hitArg;
  logic hitMode;
  logic hitCount;
  logic hitStatus;
  logic mapped;
  logic lastBlock;

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrAccess = psel && penable && pwrite && clkEn;
  // full-word address compare; the command byte rides in the mode word
  assign hitArg = (paddr == xfer_mode_pkg::ADDR_ARG);
  assign hitMode = (paddr == xfer_mode_pkg::ADDR_MODE);
  assign hitCount = (paddr == xfer_mode_pkg::ADDR_COUNT);
  assign hitStatus = (paddr == xfer_mode_pkg::ADDR_STATUS);
  assign mapped = hitArg || hitMode || hitCount || hitStatus;
  // unmapped addresses answer with an error, status is read only
  assign pslverr = psel && penable && (!mapped || (pwrite && hitStatus));

  // merge byte lanes into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // argument register
  // ****************************************************************
  // plain storage, driven straight to the frame builder
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmdArgument <= xfer_mode_pkg::ARG_RESET;
    end else if (wrAccess && hitArg) begin
      cmdArgument <= lane_merge(cmdArgument, pwdata, pstrb);
    end
  end

  // ****************************************************************
  // transfer-mode register
  // ****************************************************************
  logic [15:0] next_mode;  // write value after masking
  always_comb begin
    // only the mode half of the merged word is kept
    next_mode = 16'(lane_merge({16'h0000, modeReg}, pwdata, pstrb));
    // reserved bits forced to zero on every write
    next_mode = next_mode & xfer_mode_pkg::MODE_WMASK;
    if (!DMA_SUPPORTED) begin
      next_mode[xfer_mode_pkg::BIT_DMA] = 1'b0;
    end
  end

  // whole write dropped while the data line is busy, so a running
  // transfer never sees its mode change underneath it
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      modeReg <= xfer_mode_pkg::MODE_RESET;
    end else if (wrAccess && hitMode && |pstrb[1:0] && !dataLineBusyInhibit) begin
      modeReg <= next_mode;
    end
  end

  // field fan-out to the sequencer
  always_comb begin
    modeFields.multiBlock = modeReg[xfer_mode_pkg::BIT_MULTI];
    modeFields.readDir = modeReg[xfer_mode_pkg::BIT_DIR];
    modeFields.autoStop = modeReg[xfer_mode_pkg::BIT_AUTO_STOP];
    modeFields.countEnable = modeReg[xfer_mode_pkg::BIT_CNT_EN];
    modeFields.dmaEnable = modeReg[xfer_mode_pkg::BIT_DMA] && DMA_SUPPORTED;
  end

  // ****************************************************************
  // block counter
  // ****************************************************************
  // counts down on each block of a multi-block run only when the counter is enabled; holds at zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      blockCount <= xfer_mode_pkg::COUNT_RESET;
    end else if (clkEn) begin
      if (wrAccess && hitCount) begin
        blockCount <= 16'(lane_merge({16'h0000, blockCount}, pwdata, pstrb));
      end else if (blockDone && modeFields.multiBlock && modeFields.countEnable
                   && blockCount != 16'h0000) begin
        blockCount <= blockCount - 16'h0001;
      end
    end
  end

  // transfer type decode
  always_comb begin
    if (!modeFields.multiBlock) begin
      xferKind = xfer_mode_pkg::XFER_SINGLE;
    end else if (!modeFields.countEnable) begin
      xferKind = xfer_mode_pkg::XFER_INFINITE;
    end else if (blockCount != 16'h0000) begin
      xferKind = xfer_mode_pkg::XFER_MULTIPLE;
    end else begin
      xferKind = xfer_mode_pkg::XFER_STOP;
    end
  end

  // last block: the single one, or the counted one reaching zero
  assign lastBlock = blockDone && (!modeFields.multiBlock
                     || (modeFields.countEnable && blockCount == 16'h0001));

  // ****************************************************************
  // event pulses
  // ****************************************************************
  // stop only after a bounded multi-block run; unbounded ones are ended by software
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      autoStopIssue <= 1'b0;
    end else if (clkEn) begin
      autoStopIssue <= lastBlock && modeFields.multiBlock && modeFields.autoStop;
    end
  end

  // writing byte 00Fh is the command trigger
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dmaStart <= 1'b0;
    end else if (clkEn) begin
      dmaStart <= wrAccess && hitMode && pstrb[xfer_mode_pkg::CMD_UPPER_LANE]
                  && modeFields.dmaEnable;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // captured in the setup cycle so the access cycle sees a settled word
  // limitation: a block finishing between setup and access is not reflected
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      case (paddr)
        xfer_mode_pkg::ADDR_ARG: prdata <= cmdArgument;
        xfer_mode_pkg::ADDR_MODE: prdata <= {16'h0000, modeReg};
        xfer_mode_pkg::ADDR_COUNT: prdata <= {16'h0000, blockCount};
        xfer_mode_pkg::ADDR_STATUS: prdata <= {29'h0000_0000, dataLineBusyInhibit,
                                               xferKind};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // a write taken while the data line is busy leaves the mode word alone
  property p_busy_blocks;
    @(posedge sys_clk) disable iff (srst)
      (dataLineBusyInhibit && !penable) ##1 (dataLineBusyInhibit && wrAccess && hitMode)
      |=> $stable(modeReg);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("mode changed while busy");

  property p_mode_write;
    @(posedge sys_clk) disable iff (srst)
      (wrAccess && hitMode && pstrb[0] && !dataLineBusyInhibit)
      |=> modeReg[5:4] == $past(pwdata[5:4]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (srst) 1'b1 |-> (modeReg & 16'hFFC8) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_arg_write;
    @(posedge sys_clk) disable iff (srst)
      (wrAccess && hitArg && pstrb == 4'hF) |=> cmdArgument == $past(pwdata);
  endproperty
  a_arg_write: assert property (p_arg_write) else $error("argument not stored");

  property p_dma_start;
    @(posedge sys_clk) disable iff (srst)
      dmaStart |-> $past(modeFields.dmaEnable) && $past(pstrb[3]);
  endproperty
  a_dma_start: assert property (p_dma_start) else $error("dma start without cause");

  property p_auto_stop;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && blockDone && modeFields.multiBlock && modeFields.countEnable
       && modeFields.autoStop && blockCount == 16'h0001) |=> autoStopIssue;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("auto stop missing");

  property p_no_stop;
    @(posedge sys_clk) disable iff (srst) autoStopIssue |-> $past(modeFields.autoStop);
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("stop while disabled");

  property p_infinite;
    @(posedge sys_clk) disable iff (srst)
      (modeFields.multiBlock && !modeFields.countEnable)
      |-> xferKind == xfer_mode_pkg::XFER_INFINITE;
  endproperty
  a_infinite: assert property (p_infinite) else $error("wrong transfer kind");

  property p_count_hold;
    @(posedge sys_clk) disable iff (srst)
      (!modeFields.countEnable && !(wrAccess && hitCount)) |=> $stable(blockCount);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter ran disabled");

  property p_dma_unsup;
    @(posedge sys_clk) disable iff (srst) !DMA_SUPPORTED |-> !modeReg[0];
  endproperty
  a_dma_unsup: assert property (p_dma_unsup) else $error("dma bit without support");

  // single and stop kinds; the unbounded kind is checked above
  property p_single;
    @(posedge sys_clk) disable iff (srst)
      !modeFields.multiBlock |-> xferKind == xfer_mode_pkg::XFER_SINGLE;
  endproperty
  a_single: assert property (p_single) else $error("single kind lost");

  property p_stop_kind;
    @(posedge sys_clk) disable iff (srst)
      (modeFields.multiBlock && modeFields.countEnable && blockCount == 16'h0000)
      |-> xferKind == xfer_mode_pkg::XFER_STOP;
  endproperty
  a_stop_kind: assert property (p_stop_kind) else $error("stop kind lost");

  // a counted block takes exactly one off the remaining count
  property p_count_step;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && blockDone && modeFields.multiBlock && modeFields.countEnable
       && blockCount != 16'h0000 && !(wrAccess && hitCount))
      |=> blockCount == $past(blockCount) - 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  // a low clock enable freezes every register of the bank
  property p_freeze;
    @(posedge sys_clk) disable iff (srst)
      !clkEn |=> $stable(modeReg) && $stable(cmdArgument) && $stable(blockCount);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // one trigger write gives exactly one start pulse
  property p_dma_pulse;
    @(posedge sys_clk) disable iff (srst) dmaStart |=> !dmaStart;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse) else $error("dma start too long");

  // a mode read never shows a reserved bit
  property p_mode_read;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && psel && !penable && !pwrite && hitMode)
      |=> (prdata & 32'hFFFF_FFC8) == 32'h0000_0000;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("reserved bit read back");

  // unbounded runs never send the stop on their own; software ends them
  property p_stop_bounded;
    @(posedge sys_clk) disable iff (srst)
      autoStopIssue |-> $past(modeFields.countEnable) && $past(modeFields.multiBlock);
  endproperty
  a_stop_bounded: assert property (p_stop_bounded) else $error("stop in unbounded run");

  // main scenarios worth seeing in a run
  c_dma: cover property (@(posedge sys_clk) dmaStart);
  c_stop: cover property (@(posedge sys_clk) autoStopIssue);
  c_blocked: cover property (@(posedge sys_clk) wrAccess && hitMode && dataLineBusyInhibit);
  c_infinite: cover property (@(posedge sys_clk) xferKind == xfer_mode_pkg::XFER_INFINITE);
  c_readback: cover property (@(posedge sys_clk) psel && penable && !pwrite && hitMode);

endmodule

/* File: hw/xfer_mode_pkg.sv */
// package for the command-argument and transfer-mode register bank
// assumes an APB slave with 32-bit data and one clock domain
//
// Contract
// - 32-bit argument register feeds frame bits 39-8
// - transfer-mode writes ignored while data line busy
// - bit 5 selects multiple or single block
// - bit 4 selects read or write direction
// - bit 2 issues automatic stop after last block; the code issues it only after the last block of a counted multi-block run
// - bit 1 enables block counter, else unbounded
// - bit 0 enables DMA, reads zero if unsupported
// - DMA starts on command upper byte write
// - DMA enable only when capability allows it
// - transfer type from multiplicity, counter enable, count
package xfer_mode_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] ADDR_ARG = 12'h008;  // command_argument
  localparam logic [11:0] ADDR_MODE = 12'h00C;  // transfer_mode_control
  localparam logic [11:0] ADDR_CMD = 12'h00C;  // command word shares this word, upper half
  localparam logic [11:0] ADDR_STATUS = 12'h010;  // block status word of our own
  localparam logic [11:0] ADDR_COUNT = 12'h004;  // block count word of our own

  // ****************************************************************
  // transfer-mode field positions
  // ****************************************************************
  localparam int BIT_DMA = 0;
  localparam int BIT_CNT_EN = 1;
  localparam int BIT_AUTO_STOP = 2;
  localparam int BIT_DIR = 4;
  localparam int BIT_MULTI = 5;
  localparam logic [15:0] MODE_WMASK = 16'h0037;  // writable mode bits
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int CMD_UPPER_LANE = 3;  // byte 00Fh inside word 00Ch

  // transfer kinds decoded from mode and count
  typedef enum logic [1:0] {
    XFER_SINGLE, XFER_INFINITE, XFER_MULTIPLE, XFER_STOP
  } xfer_kind_t;

  // fields handed to the card-side sequencer
  typedef struct packed {
    logic multiBlock;
    logic readDir;
    logic autoStop;
    logic countEnable;
    logic dmaEnable;
  } mode_fields_t;

endpackage

/* File: sim/tb_card_host_xfer_mode_regs.sv */
// testbench for the command-argument and transfer-mode register bank
// assumes an APB slave that raises pready in its own time; clkEn is dropped once
module tb_card_host_xfer_mode_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic srst = 1'b1;  // held for the first two cycles
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dataLineBusyInhibit = 1'b0;  // data line idle unless a scenario says busy
  logic blockDone = 1'b0;
  logic [31:0] cmdArgument;
  xfer_mode_pkg::mode_fields_t modeFields;
  xfer_mode_pkg::xfer_kind_t xferKind;
  logic dmaStart;
  logic autoStopIssue;
  logic [31:0] rdat;  // data taken at the last completed transfer
  logic rerr;  // error flag taken at the same edge
  logic [31:0] saved;  // mode word kept across a suspend
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] modeTab [3] = '{16'h0010, 16'h0020, 16'h0026};
  logic [1:0] kindTab [3] = '{2'h0, 2'h1, 2'h2};  // single, infinite, multiple
  logic [4:0] fieldTab [3] = '{5'h08, 5'h10, 5'h16};

  card_host_xfer_mode_regs uut (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dataLineBusyInhibit(dataLineBusyInhibit), .blockDone(blockDone),
    .cmdArgument(cmdArgument), .modeFields(modeFields), .xferKind(xferKind),
    .dmaStart(dmaStart), .autoStopIssue(autoStopIssue));

  // ****************************************************************
  // clock and hang guard
  // ****************************************************************
  // 8 ns period
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // the whole sequence needs about 110 cycles; 3000 means a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      print_verdict();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the hang guard ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write, then let the register update land before anything is looked at
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
    @(posedge sys_clk);
  endtask

  // single completed block, pulse seen at one edge
  task automatic block_pulse();
    @(posedge sys_clk);
    blockDone <= 1'b1;
    @(posedge sys_clk);
    blockDone <= 1'b0;
    @(posedge sys_clk);
  endtask

  // compare of any design value, widened to a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    apb(1'b0, xfer_mode_pkg::ADDR_ARG, 32'h0, 4'h0);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, xfer_mode_pkg::ADDR_MODE, 32'h0, 4'h0);
    chk({16'h0000, rdat[15:0]}, 32'h0000_0000);
    wr(xfer_mode_pkg::ADDR_ARG, 32'hA5C3_1E7F, 4'hF);
    apb(1'b0, xfer_mode_pkg::ADDR_ARG, 32'h0, 4'h0);
    chk(rdat, 32'hA5C3_1E7F);
    chk(cmdArgument, 32'hA5C3_1E7F);
    // reserved bits dropped, every writable bit set
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_FFFF, 4'h3);
    apb(1'b0, xfer_mode_pkg::ADDR_MODE, 32'h0, 4'h0);
    chk({16'h0000, rdat[15:0]}, 32'h0000_0037);
    chk({27'h0, modeFields}, 32'h0000_001F);
    // busy data line protects the mode word
    dataLineBusyInhibit <= 1'b1;
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_0000, 4'h3);
    apb(1'b0, xfer_mode_pkg::ADDR_STATUS, 32'h0, 4'h0);
    chk(rdat, 32'h0000_0007);
    dataLineBusyInhibit <= 1'b0;
    apb(1'b0, xfer_mode_pkg::ADDR_MODE, 32'h0, 4'h0);
    chk({16'h0000, rdat[15:0]}, 32'h0000_0037);
    // transfer kinds with a count of two
    wr(xfer_mode_pkg::ADDR_COUNT, 32'h0000_0002, 4'hF);
    for (int i = 0; i < 3; i++) begin
      wr(xfer_mode_pkg::ADDR_MODE, {16'h0000, modeTab[i]}, 4'h3);
      chk({30'h0, xferKind}, {30'h0, kindTab[i]});
      chk({27'h0, modeFields}, {27'h0, fieldTab[i]});
    end
    // counted multi-block with auto stop: stop only after the last block
    block_pulse();
    chk({31'h0, autoStopIssue}, 32'h0);
    block_pulse();
    chk({31'h0, autoStopIssue}, 32'h1);
    chk({30'h0, xferKind}, 32'h3);
    apb(1'b0, xfer_mode_pkg::ADDR_COUNT, 32'h0, 4'h0);
    chk({16'h0000, rdat[15:0]}, 32'h0000_0000);
    // auto stop off: last block sends nothing
    wr(xfer_mode_pkg::ADDR_COUNT, 32'h0000_0001, 4'hF);
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_0022, 4'h3);
    block_pulse();
    chk({31'h0, autoStopIssue}, 32'h0);
    // suspend: save the mode word, let another command use it, restore it
    apb(1'b0, xfer_mode_pkg::ADDR_MODE, 32'h0, 4'h0);
    saved = rdat;
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_0010, 4'h3);
    wr(xfer_mode_pkg::ADDR_MODE, saved, 4'h3);
    apb(1'b0, xfer_mode_pkg::ADDR_MODE, 32'h0, 4'h0);
    chk({16'h0000, rdat[15:0]}, 32'h0000_0022);
    // dma start on the command upper byte, only with dma enabled
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_0001, 4'h3);
    wr(xfer_mode_pkg::ADDR_CMD, 32'h1200_0000, 4'h8);
    chk({31'h0, dmaStart}, 32'h1);
    @(posedge sys_clk);
    chk({31'h0, dmaStart}, 32'h0);
    wr(xfer_mode_pkg::ADDR_MODE, 32'h0000_0000, 4'h3);
    wr(xfer_mode_pkg::ADDR_CMD, 32'h1200_0000, 4'h8);
    chk({31'h0, dmaStart}, 32'h0);
    // frozen clock enable: an argument write does not land
    clkEn <= 1'b0;
    wr(xfer_mode_pkg::ADDR_ARG, 32'h0000_0000, 4'hF);
    clkEn <= 1'b1;
    apb(1'b0, xfer_mode_pkg::ADDR_ARG, 32'h0, 4'h0);
    chk(rdat, 32'hA5C3_1E7F);
    // unmapped address is refused
    apb(1'b0, 12'h020, 32'h0, 4'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0000_0000);
    // the status word is read only
    apb(1'b1, xfer_mode_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk({31'h0, rerr}, 32'h1);
    print_verdict();
  end
endmodule
